// ---- cdca_regs.vh ----
// register offsets, field positions and codes for the decode and add unit
`ifndef CDCA_REGS_VH
`define CDCA_REGS_VH
// register byte addresses
`define CDCA_INSTR_OFS 8'h00
`define CDCA_OPND_OFS 8'h04
`define CDCA_FLAGS_OFS 8'h08
`define CDCA_DECODE_OFS 8'h0C
`define CDCA_RESULT_OFS 8'h10
// reset values
`define CDCA_INSTR_RST 24'hFF_FFFF
`define CDCA_OPND_RST 16'h0000
`define CDCA_FLAGS_RST 8'h00
// flag bit positions
`define CDCA_FLAG_C 7
`define CDCA_FLAG_Z 6
`define CDCA_FLAG_S 5
`define CDCA_FLAG_V 4
`define CDCA_FLAG_D 3
`define CDCA_FLAG_H 2
// decode register fields
`define CDCA_DEC_CLASS_LSB 0
`define CDCA_DEC_SUB_LSB 4
`define CDCA_DEC_COND_LSB 8
`define CDCA_DEC_TAKEN 12
`define CDCA_DEC_UNDEF 13
`define CDCA_DEC_BYTES_LSB 16
`define CDCA_DEC_CYC_LSB 20
// instruction classes
`define CDCA_CL_UNDEF 4'h0
`define CDCA_CL_LD_W_R 4'h1
`define CDCA_CL_LD_R_W 4'h2
`define CDCA_CL_DECREMENT_JUMP_NONZERO 4'h3
`define CDCA_CL_RJMP 4'h4
`define CDCA_CL_LD_IMM 4'h5
`define CDCA_CL_DJMP 4'h6
`define CDCA_CL_INC 4'h7
`define CDCA_CL_CTRL 4'h8
`define CDCA_CL_ADD 4'h9
`define CDCA_CL_ADC 4'hA
// add opcode row codes (upper nibble) and timing
`define CDCA_ROW_ADD 4'h0
`define CDCA_ROW_ADC 4'h1
`define CDCA_CYC_SHORT 4'h4
`define CDCA_CYC_LONG 4'h6
`define CDCA_BYTES_SHORT 3'h2
`define CDCA_BYTES_LONG 3'h3
`endif

// ---- cdca_unit.v ----
// opcode decoder, jump condition evaluator and add datapath with apb access
//
// The APB register port and the register offsets were decided locally.
`include "cdca_regs.vh"

// Summary of operation
// RULE1 - nibbles 8-E: upper nibble is working register
// RULE2 - nibble F: sixteen single-byte control operations
// RULE3 - conditional jumps carry a 4-bit condition field
// RULE4 - condition uses only carry, zero, sign, overflow
// RULE5 - basic condition encodings per flag
// RULE6 - signed encodings use sign xor overflow
// RULE7 - unsigned above and at-most encodings
// RULE8 - alias conditions share one encoding
// RULE9 - jump taken only when condition true
// RULE10 - adc adds dst, src and carry
// RULE11 - adc sets carry, zero, sign, overflow
// RULE12 - adc clears decimal flag, sets half-carry
// RULE13 - adc encodings, sizes and cycle counts
// RULE14 - add adds dst and src, no carry
// RULE15 - add sets carry, zero, sign, overflow
// RULE16 - add clears decimal flag, sets half-carry
// RULE17 - add encodings, sizes and cycle counts
// RULE18 - operand fields: 16 working, 256 registers
// RULE19 - empty map positions stay undefined
module cdca_unit (
    input wire i_clk, // core clock
    input wire i_srst, // synchronous reset, active high
    input wire i_psel, // apb select
    input wire i_penable, // apb access phase
    input wire i_pwrite, // apb write
    input wire [7:0] i_paddr, // apb byte address
    input wire [31:0] i_pwdata, // apb write data
    output reg [31:0] o_prdata, // apb read data
    output wire o_pready, // apb ready
    output wire o_pslverr, // apb error on unmapped address
    output reg o_jump_taken, // registered jump decision
    output reg o_exec_done // pulse after an add updated flags
);

    // software visible state
    reg [23:0] instr_reg; // opcode, second and third byte
    reg [15:0] opnd_reg; // dst value low, src value high
    reg [7:0] flags_reg; // processor flags
    reg [7:0] result_reg; // last add result
    reg exec_reg; // add pending after an opcode write
    reg [7:0] flags_next; // flags after execution
    reg [7:0] result_next; // sum after execution

    // decode outputs
    reg [3:0] dec_class; // instruction class
    reg [3:0] dec_sub; // register number or control index
    reg [3:0] dec_cond; // condition field
    reg dec_undef; // empty map position
    reg [2:0] dec_bytes; // instruction length, adds only
    reg [3:0] dec_cycles; // execution cycles, adds only
    reg [7:0] dst_addr; // destination register address
    reg [7:0] src_addr; // source register address
    reg cond_true; // condition evaluation result

    // opcode field split
    wire [7:0] opc = instr_reg[7:0];
    wire [7:0] byte2 = instr_reg[15:8];
    wire [7:0] byte3 = instr_reg[23:16];
    wire [3:0] opc_hi = opc[7:4];
    wire [3:0] opc_lo = opc[3:0];

    // apb strobes and decode of the address
    wire acc = i_psel & i_penable;
    wire wr = acc & i_pwrite;
    wire hit_instr = (i_paddr == `CDCA_INSTR_OFS);
    wire hit_opnd = (i_paddr == `CDCA_OPND_OFS);
    wire hit_flags = (i_paddr == `CDCA_FLAGS_OFS);
    wire hit_dec = (i_paddr == `CDCA_DECODE_OFS);
    wire hit_res = (i_paddr == `CDCA_RESULT_OFS);
    wire mapped = hit_instr | hit_opnd | hit_flags | hit_dec | hit_res;

    // zero wait states; unmapped access is refused with an error
    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~mapped;

    // flag fields used by the condition evaluator
    wire fc = flags_reg[`CDCA_FLAG_C]; // RULE4
    wire fz = flags_reg[`CDCA_FLAG_Z]; // RULE4
    wire fs = flags_reg[`CDCA_FLAG_S]; // RULE4
    wire fv = flags_reg[`CDCA_FLAG_V]; // RULE4
    wire sxv = fs ^ fv;

    // condition evaluation; decimal and half-carry never take part
    always @*
    begin
        case (dec_cond)
            4'h0: cond_true = 1'b0; // RULE5
            4'h8: cond_true = 1'b1; // RULE5
            4'h7: cond_true = fc; // RULE5 RULE7
            4'hF: cond_true = ~fc; // RULE5 RULE7
            4'h6: cond_true = fz; // RULE5 RULE8
            4'hE: cond_true = ~fz; // RULE5 RULE8
            4'hD: cond_true = ~fs; // RULE5
            4'h5: cond_true = fs; // RULE5
            4'h4: cond_true = fv; // RULE5
            4'hC: cond_true = ~fv; // RULE5
            4'h9: cond_true = ~sxv; // RULE6
            4'h1: cond_true = sxv; // RULE6
            4'hA: cond_true = ~(fz | sxv); // RULE6
            4'h2: cond_true = fz | sxv; // RULE6
            4'hB: cond_true = ~fc & ~fz; // RULE7
            default: cond_true = fc | fz; // RULE7
        endcase
    end

    // opcode decoder
    always @*
    begin
        dec_class = `CDCA_CL_UNDEF;
        dec_sub = opc_hi;
        dec_cond = 4'h0;
        dec_undef = 1'b0;
        dec_bytes = 3'h0;
        dec_cycles = 4'h0;
        dst_addr = 8'h00;
        src_addr = 8'h00;
        if (opc_lo == 4'hF)
        begin
            // control index is the upper nibble, next .. no_operation
            dec_class = `CDCA_CL_CTRL; // RULE2
        end
        else if (opc_lo >= 4'h8)
        begin
            // upper nibble names the working register
            dec_sub = opc_hi; // RULE1
            case (opc_lo)
                4'h8: dec_class = `CDCA_CL_LD_W_R; // RULE1
                4'h9: dec_class = `CDCA_CL_LD_R_W; // RULE1
                4'hA: dec_class = `CDCA_CL_DECREMENT_JUMP_NONZERO; // RULE1
                4'hB: dec_class = `CDCA_CL_RJMP; // RULE1
                4'hC: dec_class = `CDCA_CL_LD_IMM; // RULE1
                4'hD: dec_class = `CDCA_CL_DJMP; // RULE1
                default: dec_class = `CDCA_CL_INC; // RULE1
            endcase
            // jump opcodes carry the condition in the upper nibble
            if (opc_lo == 4'hB || opc_lo == 4'hD)
            begin
                dec_cond = opc_hi; // RULE3
                dec_sub = 4'h0;
            end
        end
        else if ((opc_hi == `CDCA_ROW_ADD || opc_hi == `CDCA_ROW_ADC)
                 && opc_lo >= 4'h2 && opc_lo <= 4'h6)
        begin
            // add family in rows 0 and 1
            if (opc_hi == `CDCA_ROW_ADC)
                dec_class = `CDCA_CL_ADC;
            else
                dec_class = `CDCA_CL_ADD;
            dec_sub = opc_lo;
            if (opc_lo == 4'h2 || opc_lo == 4'h3)
            begin
                // working register forms, 2 bytes
                dec_bytes = `CDCA_BYTES_SHORT; // RULE13 RULE17
                dec_cycles = (opc_lo == 4'h2) ? `CDCA_CYC_SHORT : `CDCA_CYC_LONG; // RULE13 RULE17
                dst_addr = {4'h0, byte2[7:4]}; // RULE18
                src_addr = {4'h0, byte2[3:0]}; // RULE18
            end
            else
            begin
                // full register forms, 3 bytes
                dec_bytes = `CDCA_BYTES_LONG; // RULE13 RULE17
                dec_cycles = `CDCA_CYC_LONG; // RULE13 RULE17
                if (opc_lo == 4'h6)
                begin
                    dst_addr = byte2; // RULE18
                    src_addr = 8'h00; // immediate in third byte
                end
                else
                begin
                    dst_addr = byte3; // RULE18
                    src_addr = byte2; // RULE18
                end
            end
        end
        else
        begin
            // other rows belong elsewhere; report as not decoded here
            dec_undef = 1'b1; // RULE19
        end
    end

    // add datapath; src is already fetched (indirect or immediate)
    wire is_add = (dec_class == `CDCA_CL_ADD) | (dec_class == `CDCA_CL_ADC);
    wire [7:0] op_d = opnd_reg[7:0];
    wire [7:0] op_s = (opc_lo == 4'h6) ? byte3 : opnd_reg[15:8]; // RULE18
    wire cin = (dec_class == `CDCA_CL_ADC) ? fc : 1'b0; // RULE10 RULE14
    wire [8:0] sum9 = {1'b0, op_d} + {1'b0, op_s} + {8'h00, cin}; // RULE10 RULE14
    wire [4:0] sum_lo = {1'b0, op_d[3:0]} + {1'b0, op_s[3:0]} + {4'h0, cin};

    // flags produced by an add or add-with-carry
    always @*
    begin
        flags_next = flags_reg;
        result_next = sum9[7:0];
        flags_next[`CDCA_FLAG_C] = sum9[8]; // RULE11 RULE15
        flags_next[`CDCA_FLAG_Z] = (sum9[7:0] == 8'h00); // RULE11 RULE15
        flags_next[`CDCA_FLAG_S] = sum9[7]; // RULE11 RULE15
        flags_next[`CDCA_FLAG_V] = (op_d[7] == op_s[7]) & (sum9[7] != op_d[7]); // RULE11 RULE15
        flags_next[`CDCA_FLAG_D] = 1'b0; // RULE12 RULE16
        flags_next[`CDCA_FLAG_H] = sum_lo[4]; // RULE12 RULE16
    end

    // register writes and execution of the pending add
    always @(posedge i_clk)
    begin
        if (i_srst)
        begin
            instr_reg <= `CDCA_INSTR_RST;
            opnd_reg <= `CDCA_OPND_RST;
            flags_reg <= `CDCA_FLAGS_RST;
            result_reg <= 8'h00;
            exec_reg <= 1'b0;
            o_exec_done <= 1'b0;
            o_jump_taken <= 1'b0;
        end
        else
        begin
            // an opcode write arms one execution cycle
            exec_reg <= wr & hit_instr;
            o_exec_done <= exec_reg & is_add;
            if (wr & hit_instr)
                instr_reg <= i_pwdata[23:0];
            if (wr & hit_opnd)
                opnd_reg <= i_pwdata[15:0];
            // a software write of flags loses to a same-cycle add
            if (exec_reg & is_add)
            begin
                flags_reg <= flags_next; // RULE11 RULE12 RULE15 RULE16
                result_reg <= result_next; // RULE10 RULE14
            end
            else if (wr & hit_flags)
                flags_reg <= i_pwdata[7:0];
            // jump only on a true condition, else fall through
            o_jump_taken <= ((dec_class == `CDCA_CL_RJMP) | (dec_class == `CDCA_CL_DJMP))
                            & cond_true; // RULE9
        end
    end

    // read data captured in the setup phase, held through access
    always @(posedge i_clk)
    begin
        if (i_srst)
            o_prdata <= 32'h0000_0000;
        else if (i_psel & ~i_penable & ~i_pwrite)
        begin
            if (hit_instr)
                o_prdata <= {8'h00, instr_reg};
            else if (hit_opnd)
                o_prdata <= {16'h0000, opnd_reg};
            else if (hit_flags)
                o_prdata <= {24'h00_0000, flags_reg};
            else if (hit_dec)
                o_prdata <= {8'h00, dec_cycles, 1'b0, dec_bytes, 2'b00, dec_undef, cond_true,
                             dec_cond, dec_sub, dec_class}; // RULE3 RULE9
            else if (hit_res)
                o_prdata <= {src_addr, dst_addr, 8'h00, result_reg};
            else
                o_prdata <= 32'h0000_0000;
        end
    end

endmodule

// ---- cdca_prog_mem.sv ----
// program memory model serving hand-picked add words: {flags, src, dst, opcode}
module cdca_prog_mem (
    input wire [2:0] i_idx, // word index
    output logic [31:0] o_word // flags, source, destination, opcode
);
    timeunit 1ns;
    timeprecision 1ps;
    // carry chain, half-carry, overflow and zero-result corner cases
    always_comb
    begin
        case (i_idx)
            3'h0: o_word = 32'h80_00_FF_12;
            3'h1: o_word = 32'h80_00_0F_13;
            3'h2: o_word = 32'h00_01_7F_04;
            3'h3: o_word = 32'h00_80_80_06;
            default: o_word = 32'h00_00_00_02;
        endcase
    end
endmodule

// ---- cdca_unit_assertions.sv ----
// port-level property checks for the decode and add unit
module cdca_unit_checker (
    input wire i_clk, // core clock
    input wire i_srst, // reset
    input wire i_psel, // apb select
    input wire i_penable, // apb access
    input wire i_pwrite, // apb write
    input wire [7:0] i_paddr, // apb address
    input wire [31:0] i_pwdata, // apb write data
    input wire [31:0] o_prdata, // apb read data
    input wire o_pready, // apb ready
    input wire o_pslverr, // apb error
    input wire o_jump_taken, // jump decision
    input wire o_exec_done // add done pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire acc = i_psel && i_penable; // access phase
    wire map_hit = (i_paddr[1:0] == 2'h0) && (i_paddr <= 8'h10); // five mapped words
    wire rd_setup = i_psel && !i_penable && !i_pwrite; // read data loads here
    wire add_wr = acc && i_pwrite && (i_paddr == 8'h00) && (i_pwdata[7:5] == 3'h0)
        && (i_pwdata[3:0] >= 4'h2) && (i_pwdata[3:0] <= 4'h6); // add or adc opcode written
    reg [7:0] op_reg; // mirror of the stored opcode
    // track opcode writes so jump checks know what is stored
    always @(posedge i_clk)
    begin
        if (i_srst)
            op_reg <= 8'hFF;
        else if (acc && i_pwrite && (i_paddr == 8'h00))
            op_reg <= i_pwdata[7:0];
    end
    wire jmp_now = (op_reg[3:0] == 4'hB) || (op_reg[3:0] == 4'hD); // relative or direct jump
    a_ready_always: assert property (o_pready) else $error("ready low");
    a_err_idle: assert property (!acc |-> !o_pslverr) else $error("error outside access");
    a_err_unmapped: assert property (acc && !map_hit |-> o_pslverr) else $error("no error on unmapped");
    a_reset_clear: assert property (disable iff (1'b0) i_srst |=> o_prdata == 32'h0 && !o_jump_taken
        && !o_exec_done) else $error("outputs not cleared by reset");
    a_prdata_hold: assert property (!rd_setup |=> $stable(o_prdata)) else $error("read data moved");
    a_rd_unmapped_zero: assert property (rd_setup && !map_hit |=> o_prdata == 32'h0) else $error("bad read");
    a_exec_after_add: assert property (add_wr |-> ##[1:3] o_exec_done) else $error("no done");
    a_jump_needs_jump: assert property (o_jump_taken |-> $past(jmp_now)) else $error("jump");
    a_never_jumps: assert property ($stable(op_reg) && op_reg[7:4] == 4'h0 |-> !o_jump_taken)
        else $error("never condition jumped");
    a_always_jumps: assert property ($stable(op_reg) && op_reg == 8'h8B |-> o_jump_taken)
        else $error("always condition held");
    c_exec: cover property (o_exec_done);
    c_jump: cover property ($rose(o_jump_taken));
    c_err: cover property (o_pslverr);
endmodule

// ---- cdca_unit_tb.sv ----
// self-checking bench for the decode and add unit
`include "cdca_regs.vh"
module cdca_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_srst, i_psel, i_penable, i_pwrite; // design inputs
    logic [7:0] i_paddr; // apb address
    logic [31:0] i_pwdata, q, w; // write data, read data, program word
    logic err; // error seen on last transfer
    logic [2:0] idx; // program memory index
    logic [7:0] op, f; // opcode and flags
    wire [31:0] o_prdata; // read data
    wire [31:0] pw; // program memory output word
    wire o_pready, o_pslverr, o_jump_taken, o_exec_done; // status
    int fails, compares, i;
    cdca_unit u_cdca_unit (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .o_jump_taken, .o_exec_done);
    cdca_prog_mem u_cdca_prog_mem (.i_idx(idx), .o_word(pw));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // condition truth: low three bits pick the test, top bit inverts it
    function automatic logic cond_ok(input logic [3:0] cc, input logic [7:0] fl);
        logic c, z, s, v, r;
        {c, z, s, v} = fl[7:4];
        case (cc[2:0])
            3'h0: r = 1'b0;
            3'h1: r = s ^ v;
            3'h2: r = z | (s ^ v);
            3'h3: r = c | z;
            3'h4: r = v;
            3'h5: r = s;
            3'h6: r = z;
            default: r = c;
        endcase
        return r ^ cc[3];
    endfunction
    // expected {undefined, sub, class} of an opcode
    function automatic logic [8:0] dec_exp(input logic [7:0] o);
        if (o[3:0] == 4'hF) return {1'b0, o[7:4], 4'h8};
        if (o[3]) return {1'b0, (o[3:0] == 4'hB || o[3:0] == 4'hD) ? 4'h0 : o[7:4], o[3:0] - 4'h7};
        if (o[7:5] == 3'h0 && o[3:0] >= 4'h2 && o[3:0] <= 4'h6) return {1'b0, o[3:0], o[4] ? 4'hA : 4'h9};
        return 9'h100;
    endfunction
    // run one add or adc and compare sum, flags and timing fields
    task automatic run_add(input logic [7:0] o, input logic [7:0] d, input logic [7:0] s, input logic [7:0] fl);
        logic [8:0] sum;
        logic cin, h;
        logic [15:0] ad; // expected {source address, destination address}
        cin = o[4] & fl[7];
        sum = {1'b0, d} + {1'b0, s} + {8'h00, cin};
        h = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin}) > 5'h0F;
        // working forms split byte 2, register forms name src first, immediate has no source address
        ad = (o[3:0] <= 4'h3) ? {4'h0, d[3:0], 4'h0, d[7:4]} : ((o[3:0] == 4'h6) ? {8'h00, d} : {d, s});
        apb(1'b1, `CDCA_FLAGS_OFS, {24'h0, fl});
        apb(1'b1, `CDCA_OPND_OFS, {16'h0, s, d});
        apb(1'b1, `CDCA_INSTR_OFS, {8'h0, s, d, o});
        // done pulse stands for the one cycle after execution
        @(posedge i_clk);
        @(negedge i_clk);
        check("done", 32'(o_exec_done), 32'h1);
        @(negedge i_clk);
        check("done end", 32'(o_exec_done), 32'h0);
        apb(1'b0, `CDCA_RESULT_OFS, 32'h0);
        check("sum", 32'(q[7:0]), 32'(sum[7:0]));
        check("addr", 32'(q[31:8]), 32'({ad, 8'h00}));
        apb(1'b0, `CDCA_FLAGS_OFS, 32'h0);
        check("flags", 32'(q[7:2]), 32'({sum[8], sum[7:0] == 8'h00, sum[7],
            d[7] == s[7] && sum[7] != d[7], 1'b0, h}));
        apb(1'b0, `CDCA_DECODE_OFS, 32'h0);
        check("timing", 32'({q[23:20], q[18:16]}), 32'({o[3:0] == 4'h2 ? 4'h4 : 4'h6,
            o[3:0] >= 4'h4 ? 3'h3 : 3'h2}));
    endtask
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        fails++;
        close_out();
    end
    initial
    begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, idx} = '0;
        i_srst = 1'b1;
        void'($urandom(48));
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        apb(1'b0, `CDCA_INSTR_OFS, 32'h0);
        check("instr reset", q, 32'h00FF_FFFF);
        apb(1'b0, `CDCA_FLAGS_OFS, 32'h0);
        check("flags reset", q, 32'h0);
        $display("test reset done");
        // corner words from program memory, then random adds
        for (i = 0; i < 45; i++)
        begin
            idx = 3'(i);
            @(posedge i_clk);
            w = pw;
            if (i > 4)
                w = {8'($urandom), 8'($urandom), 8'($urandom), 3'h0, 1'($urandom), 4'($urandom_range(6, 2))};
            run_add(w[7:0], w[15:8], w[23:16], w[31:24]);
        end
        $display("test add done");
        // every condition code on both jump kinds with random flags
        for (i = 0; i < 64; i++)
        begin
            f = 8'($urandom);
            op = {4'(i), i[4] ? 4'hD : 4'hB};
            apb(1'b1, `CDCA_FLAGS_OFS, {24'h0, f});
            apb(1'b1, `CDCA_INSTR_OFS, {24'h0, op});
            // sample the registered decision where it has settled
            @(posedge i_clk);
            @(negedge i_clk);
            check("jump", 32'(o_jump_taken), 32'(cond_ok(op[7:4], f)));
            apb(1'b0, `CDCA_DECODE_OFS, 32'h0);
            check("cond", 32'(q[12:8]), 32'({cond_ok(op[7:4], f), op[7:4]}));
        end
        $display("test jump done");
        // whole opcode map
        for (i = 0; i < 256; i++)
        begin
            apb(1'b1, `CDCA_INSTR_OFS, 32'(i));
            apb(1'b0, `CDCA_DECODE_OFS, 32'h0);
            check("decode", 32'({q[13], q[13] ? 4'h0 : q[7:4], q[3:0]}), 32'(dec_exp(8'(i))));
        end
        apb(1'b1, 8'h14, 32'h0000_1234);
        check("unmapped write", 32'(err), 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped read", {q[31:1], err}, 32'h1);
        $display("test map done");
        close_out();
    end
endmodule
bind cdca_unit cdca_unit_checker u_cdca_unit_checker (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_jump_taken, .o_exec_done);
